/* hdl/lsq_cfg.svh */
// constants for the led sequencer: register map, field positions, timing
`ifndef LSQ_CFG_SVH
`define LSQ_CFG_SVH
`define LSQ_CLK_MHZ        25
`define LSQ_POR_DELAY_NS   2000
`define LSQ_ADDR_CTRL      12'h000
`define LSQ_ADDR_STATUS    12'h004
`define LSQ_ADDR_COUNT     12'h008
`define LSQ_ADDR_RECYCLE   12'h00c
`define LSQ_CTRL_DRV_EN    0
`define LSQ_CTRL_RESTART   1
`define LSQ_CTRL_RESET     1'h1
`define LSQ_RES_HALF_MIN   10'h010
`define LSQ_RES_DEAD       10'h002
`define LSQ_DC_FLT_LOW_CNT 9'h040
`define LSQ_DC_FLT_L2_CNT  9'h100
`define LSQ_LED_FLT_CNT    9'h100
`define LSQ_BLANK_CNT      4'hf
`define LSQ_RECYCLE_BITS   19
`endif

/* hdl/lsq_pkg.sv */
// shared types of the led sequencer
package lsq_pkg;
	typedef struct packed {
		logic led_open;
		logic led_oc;
		logic led_ov;
		logic gnd_short;
		logic rect_short;
		logic dc_ov;
		logic dc_oc;
	} lsq_fault_type;

	typedef enum logic [2:0] {
		LSQ_SEQ_POR  = 3'b001,
		LSQ_SEQ_SOFT = 3'b010,
		LSQ_SEQ_RUN  = 3'b100
	} lsq_seq_type;
endpackage

/* hdl/lsq_sync3.sv */
// three-stage input synchroniser, output follows once stages two and three agree
`timescale 1ns/1ps
module lsq_sync3 #(
	parameter int W = 1
) (
	input  wire logic         clk_i,   // system clock
	input  wire logic         rst_i,   // synchronous reset, high
	input  wire logic [W-1:0] async_i, // asynchronous pins
	output logic      [W-1:0] sync_o   // filtered, synchronised level
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
		end else begin
			s1 <= async_i;
			s2 <= s1;
			s3 <= s2;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			sync_o <= '0;
		else
			sync_o <= (s2 & s3) | (sync_o & (s2 | s3));
	end
endmodule // lsq_sync3

/* hdl/lsq_tick_counter.sv */
// saturating counter that advances on oscillator ticks while its condition holds
`timescale 1ns/1ps
module lsq_tick_counter #(
	parameter int             WIDTH = 9,
	parameter logic [WIDTH-1:0] FULL = '1
) (
	input  wire logic             clk_i,    // system clock
	input  wire logic             rst_i,    // synchronous reset, high
	input  wire logic             clear_i,  // restart clear
	input  wire logic             tick_i,   // oscillator tick
	input  wire logic             active_i, // condition present
	output logic      [WIDTH-1:0] count_o,  // present count
	output logic                  full_o    // count reached full
);
	assign full_o = (count_o == FULL);

	always_ff @(posedge clk_i) begin
		if (rst_i || clear_i || !active_i)
			count_o <= '0; // [RULE_21]
		else if (tick_i && !full_o)
			count_o <= count_o + 1'b1; // [RULE_20]
	end
endmodule // lsq_tick_counter

/* hdl/lsq_top.sv */
// sequencing, drive timing and fault protection of the led / dc controller
// Functional notes
// RULE_01: resonant phases one and two in antiphase, near full duty, rate from dc error.
// RULE_02: burst mode emits whole pairs only, phase one first, phase two last.
// RULE_03: sync zero crossing resets led ramp; switch rises there, width from led error.
// RULE_04: after reset detach soft-start node and enable its charging source.
// RULE_05: at soft-start threshold stop the source and reconnect dimming integrator.
// RULE_06: release dc clamp at soft-start threshold or first dc feedback at reference.
// RULE_07: led held off in soft start; run flag; led needs run, enable and dim.
// RULE_08: any protection shutdown starts recycle counter; full count restarts the system.
// RULE_09: each fault comes from its own sense input comparator.
// RULE_10: led open, overcurrent or overvoltage stops only led switch, starts recycle.
// RULE_11: ground short or rectifier short stops all three drives at once.
// RULE_12: dc fault counts; at 64 drive fault pin low and start recycle.
// RULE_13: dc fault clears: restart on recycle; persists to 256: level two, all off.
// RULE_14: open-led detection blanked for 15 ticks after each dim rising edge.
// RULE_15: open led after blanking counts; at 256 set led fault, fault pin high.
// RULE_16: outside logic removes dc load and led supply when fault pin is low.
// RULE_17: resonant drives stop while dc error is below the shutdown level.
// RULE_18: reset clears counters and latches, discharges node, drives inactive.
// RULE_19: enable cycling or recycle pulse clears faults and restarts start-up.
// RULE_20: all counters advance on the resonant oscillator tick; por_cnt and the led ramp here advance every clock.
// RULE_21: fault counter advances only while fault present, clears otherwise.
`timescale 1ns/1ps
`include "lsq_cfg.svh"
module lsq_top
	import lsq_pkg::*;
#(
	parameter int RECYCLE_BITS = `LSQ_RECYCLE_BITS
) (
	input  wire logic        CLOCK_I,          // 25 MHz system clock
	input  wire logic        SYS_RST_I,        // synchronous reset, high
	input  wire logic        PSEL_I,           // apb select
	input  wire logic        PENABLE_I,        // apb enable
	input  wire logic        PWRITE_I,         // apb direction
	input  wire logic [11:0] PADDR_I,          // apb byte address
	input  wire logic [31:0] PWDATA_I,         // apb write data
	output logic      [31:0] PRDATA_O,         // apb read data
	output logic             PREADY_O,         // apb ready
	output logic             PSLVERR_O,        // apb error on unmapped address
	input  wire logic [7:0]  DC_LOOP_ERROR_LEVEL_I,  // digitised dc error, sets rate
	input  wire logic [7:0]  LED_LOOP_ERROR_LEVEL_I, // digitised led error, sets width
	input  wire logic        DC_ERR_BELOW_SHUTDOWN_I, // dc error under shutdown level
	input  wire logic        SYNC_ZERO_CROSS_I,  // transformer sync comparator
	input  wire logic        ENABLE_I,           // led enable pin
	input  wire logic        DIM_I,              // burst dimming input
	input  wire logic        SS_AT_THRESHOLD_I,  // soft-start node at threshold
	input  wire logic        DC_FB_AT_REF_I,     // dc feedback reached reference
	input  wire lsq_fault_type FAULT_SENSE_I,    // fault comparator outputs
	input  wire logic        FAULT_INDICATOR_OUT_I,    // fault pin level
	output logic             FAULT_INDICATOR_OUT_O,    // fault pin drive value
	output logic             FAULT_INDICATOR_OUT_OE_N_O, // low while driving
	output logic             RESONANT_PHASE_ONE_DRIVE_O, // phase one gate drive
	output logic             RESONANT_PHASE_TWO_DRIVE_O, // phase two gate drive
	output logic             LED_SWITCH_DRIVE_O,         // led switch gate drive
	output logic             SS_DISCHARGE_O,   // discharge soft-start node
	output logic             SS_SOURCE_EN_O,   // soft-start charging source on
	output logic             SS_DETACH_O,      // node detached from integrator
	output logic             DC_CLAMP_O,       // soft-start clamp on dc loop
	output logic             RUN_FLAG_O        // soft start complete
);
	localparam int POR_CYC_RAW = (`LSQ_POR_DELAY_NS * `LSQ_CLK_MHZ + 999) / 1000;
	localparam logic [15:0] POR_CYC = 16'(POR_CYC_RAW < 1 ? 1 : POR_CYC_RAW);

	logic [13:0]         pin_s;
	logic                burst_low;
	logic                sync_s;
	logic                enable_s;
	logic                dim_s;
	logic                ss_thr;
	logic                fb_ref;
	logic                fault_pin_s;
	lsq_fault_type       flt;
	logic                sync_d;
	logic                enable_d;
	logic                dim_d;
	lsq_seq_type         seq;
	lsq_seq_type         next_seq;
	logic [15:0]         por_cnt;
	logic                clamp_released;
	logic                drv_en;
	logic                restart_req;
	logic                soft_rst;
	logic [9:0]          osc_cnt;
	logic [9:0]          half;
	logic                tick;
	logic                pair_active;
	logic                res_allow;
	logic                hard_stop;
	logic                led_stop;
	logic                led_fault;
	logic                dc_flt_low;
	logic                dc_level2;
	logic                led_allow;
	logic [7:0]          ramp;
	logic [7:0]          next_ramp;
	logic [3:0]          blank_cnt;
	logic [8:0]          dc_cnt;
	logic                dc_full;
	logic [8:0]          led_cnt;
	logic                led_full;
	logic [RECYCLE_BITS-1:0] rec_cnt;
	logic                rec_full;
	logic                rec_active;
	logic [31:0]         rd_val;
	logic                rd_ok;

	lsq_sync3 #(.W(14)) u_sync (
		.clk_i   (CLOCK_I),
		.rst_i   (SYS_RST_I),
		.async_i ({DC_ERR_BELOW_SHUTDOWN_I, SYNC_ZERO_CROSS_I, ENABLE_I, DIM_I,
		           SS_AT_THRESHOLD_I, DC_FB_AT_REF_I, FAULT_INDICATOR_OUT_I,
		           FAULT_SENSE_I}),
		.sync_o  (pin_s)
	);
	assign {burst_low, sync_s, enable_s, dim_s, ss_thr, fb_ref, fault_pin_s} = pin_s[13:7];
	assign flt = lsq_fault_type'(pin_s[6:0]); // [RULE_09]

	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			sync_d   <= 1'b0;
			enable_d <= 1'b0;
			dim_d    <= 1'b0;
		end else begin
			sync_d   <= sync_s;
			enable_d <= enable_s;
			dim_d    <= dim_s;
		end
	end

	// enable falling edge, recycle pulse or software restart all rerun start-up
	assign soft_rst = (enable_d && !enable_s) || rec_full || restart_req; // [RULE_19] [RULE_08]

	// start-up sequencer
	always_comb begin
		next_seq = seq;
		unique case (seq)
			LSQ_SEQ_POR:  if (por_cnt >= POR_CYC - 16'h0001) next_seq = LSQ_SEQ_SOFT;
			LSQ_SEQ_SOFT: if (ss_thr) next_seq = LSQ_SEQ_RUN; // [RULE_05]
			LSQ_SEQ_RUN:  next_seq = LSQ_SEQ_RUN;
		endcase
	end

	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I || soft_rst) begin
			seq     <= LSQ_SEQ_POR; // [RULE_18] [RULE_19]
			por_cnt <= 16'h0000;
		end else begin
			seq     <= next_seq;
			por_cnt <= (seq == LSQ_SEQ_POR) ? por_cnt + 16'h0001 : 16'h0000;
		end
	end

	// feedback reaching reference releases the clamp early and stays released
	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I || soft_rst)
			clamp_released <= 1'b0;
		else if (seq == LSQ_SEQ_SOFT && fb_ref)
			clamp_released <= 1'b1; // [RULE_06]
	end

	// resonant oscillator: period latched at wrap so both halves stay equal
	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			osc_cnt <= 10'h000;
			half    <= `LSQ_RES_HALF_MIN;
		end else if (tick) begin
			osc_cnt <= 10'h000;
			half    <= `LSQ_RES_HALF_MIN + {2'b00, ~DC_LOOP_ERROR_LEVEL_I}; // [RULE_01]
		end else begin
			osc_cnt <= osc_cnt + 10'h001;
		end
	end
	assign tick = (osc_cnt == {half[8:0], 1'b0} - 10'h001); // [RULE_20]

	assign hard_stop = flt.gnd_short || flt.rect_short || dc_level2; // [RULE_11] [RULE_13]
	assign res_allow = drv_en && (seq != LSQ_SEQ_POR) && !burst_low; // [RULE_17]

	// a pair is granted only at the period boundary, so burst gaps never split one
	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I || hard_stop || seq == LSQ_SEQ_POR)
			pair_active <= 1'b0; // [RULE_11] [RULE_18]
		else if (tick)
			pair_active <= res_allow; // [RULE_02]
	end

	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I || hard_stop || !pair_active) begin
			RESONANT_PHASE_ONE_DRIVE_O <= 1'b0; // [RULE_11]
			RESONANT_PHASE_TWO_DRIVE_O <= 1'b0;
		end else begin
			RESONANT_PHASE_ONE_DRIVE_O <= (osc_cnt < half - `LSQ_RES_DEAD); // [RULE_01] [RULE_02]
			RESONANT_PHASE_TWO_DRIVE_O <= (osc_cnt >= half) &&
				(osc_cnt < {half[8:0], 1'b0} - `LSQ_RES_DEAD); // [RULE_01]
		end
	end

	// led ramp restarts at each sync rising crossing; switch turns on there
	assign led_allow = (seq == LSQ_SEQ_RUN) && enable_s && dim_s && !led_stop
		&& !hard_stop; // [RULE_07] [RULE_10] [RULE_11]

	always_comb begin
		next_ramp = (ramp == 8'hff) ? ramp : ramp + 8'h01;
		if (sync_s && !sync_d)
			next_ramp = 8'h00; // [RULE_03]
	end

	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			ramp               <= 8'h00;
			LED_SWITCH_DRIVE_O <= 1'b0;
		end else begin
			ramp               <= next_ramp;
			LED_SWITCH_DRIVE_O <= led_allow && (next_ramp < LED_LOOP_ERROR_LEVEL_I); // [RULE_03]
		end
	end

	// open-led blanking after each dim rising edge
	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I || soft_rst)
			blank_cnt <= 4'h0;
		else if (dim_s && !dim_d)
			blank_cnt <= `LSQ_BLANK_CNT; // [RULE_14]
		else if (tick && blank_cnt != 4'h0)
			blank_cnt <= blank_cnt - 4'h1; // [RULE_20]
	end

	lsq_tick_counter #(.WIDTH(9), .FULL(`LSQ_DC_FLT_L2_CNT)) u_dc_cnt (
		.clk_i    (CLOCK_I),
		.rst_i    (SYS_RST_I),
		.clear_i  (soft_rst),
		.tick_i   (tick),
		.active_i (flt.dc_ov || flt.dc_oc), // [RULE_12]
		.count_o  (dc_cnt),
		.full_o   (dc_full)
	);

	lsq_tick_counter #(.WIDTH(9), .FULL(`LSQ_LED_FLT_CNT)) u_led_cnt (
		.clk_i    (CLOCK_I),
		.rst_i    (SYS_RST_I),
		.clear_i  (soft_rst),
		.tick_i   (tick),
		.active_i (flt.led_open && dim_s && blank_cnt == 4'h0), // [RULE_14] [RULE_15]
		.count_o  (led_cnt),
		.full_o   (led_full)
	);

	lsq_tick_counter #(.WIDTH(RECYCLE_BITS)) u_recycle (
		.clk_i    (CLOCK_I),
		.rst_i    (SYS_RST_I),
		.clear_i  (soft_rst),
		.tick_i   (tick),
		.active_i (rec_active), // [RULE_08]
		.count_o  (rec_cnt),
		.full_o   (rec_full)
	);

	// protection latches hold until a restart; a new fault in that cycle is re-seen next cycle
	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I || soft_rst) begin
			led_stop   <= 1'b0; // [RULE_18] [RULE_19]
			led_fault  <= 1'b0;
			dc_flt_low <= 1'b0;
			dc_level2  <= 1'b0;
			rec_active <= 1'b0;
		end else begin
			if (flt.led_oc || flt.led_ov || led_full)
				led_stop <= 1'b1; // [RULE_10]
			if (led_full)
				led_fault <= 1'b1; // [RULE_15]
			if (dc_cnt >= `LSQ_DC_FLT_LOW_CNT)
				dc_flt_low <= 1'b1; // [RULE_12]
			if (dc_full)
				dc_level2 <= 1'b1; // [RULE_13]
			if (led_stop || dc_flt_low || hard_stop)
				rec_active <= 1'b1; // [RULE_08] [RULE_10] [RULE_12]
		end
	end

	// fault pin: dc fault pulls low and wins over led fault, which pulls high
	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			FAULT_INDICATOR_OUT_O      <= 1'b1;
			FAULT_INDICATOR_OUT_OE_N_O <= 1'b1;
		end else begin
			FAULT_INDICATOR_OUT_O      <= !dc_flt_low; // [RULE_12] [RULE_15]
			FAULT_INDICATOR_OUT_OE_N_O <= !(dc_flt_low || led_fault); // [RULE_16]
		end
	end

	// soft-start pins
	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			SS_DISCHARGE_O <= 1'b1; // [RULE_18]
			SS_SOURCE_EN_O <= 1'b0;
			SS_DETACH_O    <= 1'b1;
			DC_CLAMP_O     <= 1'b1;
			RUN_FLAG_O     <= 1'b0;
		end else begin
			SS_DISCHARGE_O <= (seq == LSQ_SEQ_POR);
			SS_SOURCE_EN_O <= (seq == LSQ_SEQ_SOFT); // [RULE_04] [RULE_05]
			SS_DETACH_O    <= (seq != LSQ_SEQ_RUN); // [RULE_04]
			DC_CLAMP_O     <= (seq != LSQ_SEQ_RUN) && !clamp_released; // [RULE_06]
			RUN_FLAG_O     <= (seq == LSQ_SEQ_RUN); // [RULE_07]
		end
	end

	// apb slave: one wait-free answer, ready one cycle after setup
	always_comb begin
		rd_ok  = 1'b1;
		rd_val = 32'h0000_0000;
		unique case (PADDR_I)
			`LSQ_ADDR_CTRL:    rd_val[`LSQ_CTRL_DRV_EN] = drv_en;
			`LSQ_ADDR_STATUS:  rd_val = {21'h000000, seq, fault_pin_s, rec_active,
				hard_stop, led_fault, led_stop, dc_level2, dc_flt_low, RUN_FLAG_O};
			`LSQ_ADDR_COUNT:   rd_val = {7'h00, led_cnt, 7'h00, dc_cnt};
			`LSQ_ADDR_RECYCLE: rd_val[RECYCLE_BITS-1:0] = rec_cnt;
			default:           rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			PREADY_O  <= 1'b0;
			PSLVERR_O <= 1'b0;
			PRDATA_O  <= 32'h0000_0000;
		end else begin
			PREADY_O  <= PSEL_I && !PENABLE_I;
			PSLVERR_O <= PSEL_I && !PENABLE_I && !rd_ok;
			PRDATA_O  <= (PSEL_I && !PENABLE_I && !PWRITE_I) ? rd_val : 32'h0000_0000;
		end
	end

	// control register; restart bit is a self-clearing strobe
	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			drv_en      <= `LSQ_CTRL_RESET;
			restart_req <= 1'b0;
		end else begin
			restart_req <= 1'b0;
			if (PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PADDR_I == `LSQ_ADDR_CTRL) begin
				drv_en      <= PWDATA_I[`LSQ_CTRL_DRV_EN];
				restart_req <= PWDATA_I[`LSQ_CTRL_RESTART]; // [RULE_19]
			end
		end
	end
endmodule // lsq_top

/* testbench/lsq_stage_model.sv */
// far side: sync winding, soft-start node, dc load switch and fault pin pull-up
`timescale 1ns/1ps
module lsq_stage_model (
	input  wire logic       clk_i,  // clock
	input  wire logic       rst_i,  // reset
	input  wire logic       src_i,  // soft-start source on
	input  wire logic       dis_i,  // soft-start discharge
	input  wire logic       oe_n_i, // fault pin enable, low drives
	input  wire logic       drv_i,  // fault pin value
	input  wire logic       fb_i,   // feedback at reference request
	input  wire logic       ov_i,   // removable dc overvoltage
	input  wire logic       oc_i,   // persistent dc overcurrent
	output logic            sync_o, // zero-cross comparator
	output logic            ss_o,   // node at threshold
	output logic            fb_o,   // feedback at reference
	output logic      [1:0] dc_o,   // dc_ov, dc_oc
	output logic            pin_o   // fault pin level
);
	logic [6:0] ph;
	logic [7:0] ss_cnt;
	logic       load_off;
	always_ff @(posedge clk_i) begin
		ph <= rst_i ? 7'h00 : ph + 7'h01;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i || dis_i) ss_cnt <= 8'h00;
		else if (src_i && ss_cnt != 8'hff) ss_cnt <= ss_cnt + 8'h01;
	end
	// load stays off until the overvoltage request is withdrawn
	always_ff @(posedge clk_i) begin
		if (rst_i) load_off <= 1'b0;
		else if (!oe_n_i && !drv_i) load_off <= 1'b1;
		else if (!ov_i) load_off <= 1'b0;
	end
	assign sync_o = ph[6];
	assign ss_o = ss_cnt > 8'h63;
	assign fb_o = fb_i;
	assign dc_o = {ov_i && !load_off, oc_i};
	assign pin_o = oe_n_i ? 1'b1 : drv_i; // pull-up when released
endmodule // lsq_stage_model

/* testbench/lsq_top_chk.sv */
// port assertions for the led sequencer
`timescale 1ns/1ps
module lsq_top_chk
	import lsq_pkg::*;
(
	input wire logic          CLOCK_I,                    // clock
	input wire logic          SYS_RST_I,                  // reset
	input wire logic          PSEL_I,                     // apb select
	input wire logic          PENABLE_I,                  // apb enable
	input wire logic          PREADY_O,                   // apb ready
	input wire logic          DC_ERR_BELOW_SHUTDOWN_I,    // burst stop
	input wire lsq_fault_type FAULT_SENSE_I,              // faults
	input wire logic          RESONANT_PHASE_ONE_DRIVE_O, // phase one
	input wire logic          RESONANT_PHASE_TWO_DRIVE_O, // phase two
	input wire logic          LED_SWITCH_DRIVE_O,         // led switch
	input wire logic          SS_DISCHARGE_O,             // discharge
	input wire logic          SS_SOURCE_EN_O,             // source
	input wire logic          SS_DETACH_O,                // detach
	input wire logic          DC_CLAMP_O,                 // clamp
	input wire logic          RUN_FLAG_O,                 // run
	input wire logic          FAULT_INDICATOR_OUT_OE_N_O  // pin release
);
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (SYS_RST_I);
	logic [3:0] below_cnt;
	logic       hard;
	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I || !DC_ERR_BELOW_SHUTDOWN_I) below_cnt <= 4'h0;
		else if (below_cnt != 4'hf) below_cnt <= below_cnt + 4'h1;
	end
	// shorts and dc faults may cut a pair; a restart cuts one too and shows as discharge
	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I) hard <= 1'b0;
		else if (|FAULT_SENSE_I[3:0] || $fell(RUN_FLAG_O)) hard <= 1'b1;
	end
	sequence pair_end;
		$fell(RESONANT_PHASE_ONE_DRIVE_O) && !hard;
	endsequence
	sequence pair_close;
		##[1:6] ($rose(RESONANT_PHASE_TWO_DRIVE_O) || SS_DISCHARGE_O);
	endsequence
	chk_phase_antiphase: assert property (
		!(RESONANT_PHASE_ONE_DRIVE_O && RESONANT_PHASE_TWO_DRIVE_O))
		else $error("both phases on");
	chk_pair_order: assert property (pair_end |-> pair_close)
		else $error("phase two did not follow phase one");
	chk_burst_hold: assert property ($rose(RESONANT_PHASE_ONE_DRIVE_O) |-> below_cnt < 4'ha)
		else $error("pair started below shutdown");
	chk_led_run: assert property (
		LED_SWITCH_DRIVE_O |-> RUN_FLAG_O || $past(RUN_FLAG_O))
		else $error("led drive without run");
	chk_src_detach: assert property (
		SS_SOURCE_EN_O |-> SS_DETACH_O && !SS_DISCHARGE_O)
		else $error("source on while attached");
	chk_run_done: assert property (
		RUN_FLAG_O |-> !SS_SOURCE_EN_O && !SS_DETACH_O && !DC_CLAMP_O)
		else $error("soft start left on in run");
	chk_rst_idle: assert property (disable iff (1'b0) SYS_RST_I |=>
		!RESONANT_PHASE_ONE_DRIVE_O && !RESONANT_PHASE_TWO_DRIVE_O && !LED_SWITCH_DRIVE_O
		&& SS_DISCHARGE_O && FAULT_INDICATOR_OUT_OE_N_O && !RUN_FLAG_O)
		else $error("outputs not idle in reset");
	chk_short_off: assert property (
		(FAULT_SENSE_I.gnd_short || FAULT_SENSE_I.rect_short) [*8] |->
		!RESONANT_PHASE_ONE_DRIVE_O && !RESONANT_PHASE_TWO_DRIVE_O && !LED_SWITCH_DRIVE_O)
		else $error("drive on during short");
	chk_ready_pulse: assert property (PSEL_I && !PENABLE_I |=> PREADY_O ##1 !PREADY_O)
		else $error("ready not a single pulse after setup");
endmodule // lsq_top_chk

/* testbench/lsq_top_test.sv */
// self-checking bench for the led sequencer
`timescale 1ns/1ps
`include "lsq_cfg.svh"
module lsq_top_test;
	import lsq_pkg::*;
	localparam logic [11:0] ST = `LSQ_ADDR_STATUS;
	localparam logic [11:0] CT = `LSQ_ADDR_CTRL;
	logic          CLOCK_I, SYS_RST_I, PSEL_I, PENABLE_I, PWRITE_I, PREADY_O, PSLVERR_O;
	logic [11:0]   PADDR_I;
	logic [31:0]   PWDATA_I, PRDATA_O, rd;
	logic [7:0]    DC_LOOP_ERROR_LEVEL_I, LED_LOOP_ERROR_LEVEL_I;
	logic          DC_ERR_BELOW_SHUTDOWN_I, SYNC_ZERO_CROSS_I, ENABLE_I, DIM_I;
	logic          SS_AT_THRESHOLD_I, DC_FB_AT_REF_I, FAULT_INDICATOR_OUT_I;
	logic          FAULT_INDICATOR_OUT_O, FAULT_INDICATOR_OUT_OE_N_O, LED_SWITCH_DRIVE_O;
	logic          RESONANT_PHASE_ONE_DRIVE_O, RESONANT_PHASE_TWO_DRIVE_O, SS_DISCHARGE_O;
	logic          SS_SOURCE_EN_O, SS_DETACH_O, DC_CLAMP_O, RUN_FLAG_O, err, fb, ov, oc;
	logic [4:0]    flt;
	logic [1:0]    dc;
	lsq_fault_type FAULT_SENSE_I;
	int            n_errors, num_checks, c1, c2, cl;
	assign FAULT_SENSE_I = {flt, dc};
	lsq_top #(.RECYCLE_BITS(9)) uut (.*);
	lsq_stage_model u_stage (.clk_i(CLOCK_I), .rst_i(SYS_RST_I), .src_i(SS_SOURCE_EN_O),
		.dis_i(SS_DISCHARGE_O), .oe_n_i(FAULT_INDICATOR_OUT_OE_N_O),
		.drv_i(FAULT_INDICATOR_OUT_O), .fb_i(fb), .ov_i(ov), .oc_i(oc),
		.sync_o(SYNC_ZERO_CROSS_I), .ss_o(SS_AT_THRESHOLD_I), .fb_o(DC_FB_AT_REF_I),
		.dc_o(dc), .pin_o(FAULT_INDICATOR_OUT_I));
	initial begin
		CLOCK_I = 1'b0;
		forever #20 CLOCK_I = ~CLOCK_I;
	end
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic timeout(input string nm);
		n_errors++;
		$display("unexpected %s expected done seen timeout", nm);
		wrap_up();
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		@(posedge CLOCK_I);
		PSEL_I <= 1'b1;
		PWRITE_I <= wr;
		PADDR_I <= a;
		PWDATA_I <= wd;
		@(posedge CLOCK_I);
		PENABLE_I <= 1'b1;
		n = 0;
		do begin
			@(posedge CLOCK_I);
			n++;
		end while (PREADY_O !== 1'b1 && n < 20);
		if (PREADY_O !== 1'b1) timeout("apb ready");
		rd = PRDATA_O;
		err = PSLVERR_O;
		PSEL_I <= 1'b0;
		PENABLE_I <= 1'b0;
	endtask
	task automatic poll(input logic [31:0] m, input logic [31:0] v);
		for (int n = 0; n < 8000; n++) begin
			apb(1'b0, ST, 32'h0);
			if ((rd & m) === v) return;
		end
		timeout("status poll");
	endtask
	task automatic obs(input int cyc);
		c1 = 0;
		c2 = 0;
		cl = 0;
		repeat (cyc) begin
			@(posedge CLOCK_I);
			c1 += (RESONANT_PHASE_ONE_DRIVE_O === 1'b1);
			c2 += (RESONANT_PHASE_TWO_DRIVE_O === 1'b1);
			cl += (LED_SWITCH_DRIVE_O !== 1'b0);
		end
	endtask
	task automatic boot();
		@(posedge CLOCK_I);
		SYS_RST_I <= 1'b1;
		repeat (3) @(posedge CLOCK_I);
		SYS_RST_I <= 1'b0;
		poll(32'h1, 32'h1);
	endtask
	task automatic s_regs();
		boot();
		check("soft start", {SS_SOURCE_EN_O, SS_DETACH_O, DC_CLAMP_O}, 32'h0);
		apb(1'b0, ST, 32'h0);
		check("seq", rd[10:8], 32'h4);
		apb(1'b0, CT, 32'h0);
		check("ctrl", rd, 32'h1);
		apb(1'b0, 12'h010, 32'h0);
		check("unmapped", {rd[30:0], err}, 32'h1);
		fb <= 1'b1;
		apb(1'b1, CT, 32'h3);
		repeat (4) @(posedge CLOCK_I);
		check("restart", {SS_DISCHARGE_O, SS_DETACH_O, RUN_FLAG_O}, 32'h6);
		repeat (80) @(posedge CLOCK_I);
		check("early release", {RUN_FLAG_O, DC_CLAMP_O, SS_SOURCE_EN_O}, 32'h1);
		fb <= 1'b0;
		apb(1'b0, CT, 32'h0);
		check("ctrl after restart", rd, 32'h1);
	endtask
	task automatic s_led();
		int n;
		int w;
		boot();
		for (n = 0; n < 400 && LED_SWITCH_DRIVE_O !== 1'b1; n++) @(posedge CLOCK_I);
		for (w = 0; w < 400 && LED_SWITCH_DRIVE_O === 1'b1; w++) @(posedge CLOCK_I);
		check("led width", w, 32'ha);
		DIM_I <= 1'b0;
		repeat (20) @(posedge CLOCK_I);
		obs(300);
		check("undimmed", {cl == 0, c1 > 50, c2 > 50}, 32'h7);
		DIM_I <= 1'b1;
		ENABLE_I <= 1'b0;
		repeat (12) @(posedge CLOCK_I);
		check("enable cycle", SS_DISCHARGE_O, 32'h1);
		ENABLE_I <= 1'b1;
		DC_ERR_BELOW_SHUTDOWN_I <= 1'b1;
		repeat (300) @(posedge CLOCK_I);
		obs(300);
		check("burst stop", c1 + c2, 32'h0);
		DC_ERR_BELOW_SHUTDOWN_I <= 1'b0;
		obs(300);
		check("burst resume", {c1 != 0, c2 != 0}, 32'h3);
		// a lower dc error doubles the half period to 32, phase one on for 30
		DC_LOOP_ERROR_LEVEL_I <= 8'hef;
		repeat (100) @(posedge CLOCK_I);
		for (n = 0; n < 400 && RESONANT_PHASE_ONE_DRIVE_O !== 1'b0; n++) @(posedge CLOCK_I);
		for (n = 0; n < 400 && RESONANT_PHASE_ONE_DRIVE_O !== 1'b1; n++) @(posedge CLOCK_I);
		for (w = 0; w < 400 && RESONANT_PHASE_ONE_DRIVE_O === 1'b1; w++) @(posedge CLOCK_I);
		check("phase width", w, 32'h1e);
		DC_LOOP_ERROR_LEVEL_I <= 8'hff;
	endtask
	task automatic s_fault();
		for (int n = 0; n < 4; n++) begin
			boot();
			flt <= 5'h08 >> n;
			repeat (20) @(posedge CLOCK_I);
			obs(200);
			flt <= 5'h00;
			check("fault stop", {cl == 0, c1 != 0, c2 != 0}, n < 2 ? 32'h7 : 32'h4);
		end
	endtask
	task automatic s_dc();
		boot();
		ov <= 1'b1;
		repeat (1900) @(posedge CLOCK_I);
		check("pin early", FAULT_INDICATOR_OUT_OE_N_O, 32'h1);
		poll(32'h2, 32'h2);
		check("pin low", {FAULT_INDICATOR_OUT_OE_N_O, FAULT_INDICATOR_OUT_O}, 32'h0);
		apb(1'b0, ST, 32'h0);
		check("recycle on", rd[6], 32'h1);
		poll(32'h2, 32'h0);
		check("pin freed", FAULT_INDICATOR_OUT_OE_N_O, 32'h1);
		ov <= 1'b0;
		boot();
		oc <= 1'b1;
		poll(32'h4, 32'h4);
		obs(100);
		check("level two", c1 + c2 + cl, 32'h0);
		oc <= 1'b0;
	endtask
	task automatic s_open();
		boot();
		flt <= 5'h10;
		DIM_I <= 1'b0;
		repeat (40) @(posedge CLOCK_I);
		DIM_I <= 1'b1;
		repeat (400) @(posedge CLOCK_I);
		apb(1'b0, `LSQ_ADDR_COUNT, 32'h0);
		check("blanked", rd[24:16], 32'h0);
		repeat (500) @(posedge CLOCK_I);
		apb(1'b0, `LSQ_ADDR_COUNT, 32'h0);
		check("open counting", rd[24:16] != 0, 32'h1);
		flt <= 5'h00;
		repeat (100) @(posedge CLOCK_I);
		apb(1'b0, `LSQ_ADDR_COUNT, 32'h0);
		check("open cleared", rd[24:16], 32'h0);
		flt <= 5'h10;
		poll(32'h10, 32'h10);
		check("pin high", {FAULT_INDICATOR_OUT_OE_N_O, FAULT_INDICATOR_OUT_O}, 32'h1);
		flt <= 5'h00;
	endtask
	initial begin
		SYS_RST_I = 1'b1;
		{PSEL_I, PENABLE_I, PWRITE_I, PADDR_I, PWDATA_I} = '0;
		DC_LOOP_ERROR_LEVEL_I = 8'hff;
		LED_LOOP_ERROR_LEVEL_I = 8'h0a;
		{ENABLE_I, DIM_I, DC_ERR_BELOW_SHUTDOWN_I} = 3'h6;
		{flt, fb, ov, oc} = '0;
		repeat (12) @(posedge CLOCK_I);
		SYS_RST_I <= 1'b0;
		s_regs();
		s_led();
		s_fault();
		s_dc();
		s_open();
		wrap_up();
	end
endmodule // lsq_top_test
bind lsq_top lsq_top_chk u_chk (.*);
